/* File: shs_homing_sequencer.sv */
// Purpose: Homing sequencer for methods 10 to 14 and 17 to 19 with Avalon-MM registers
// Assumes: Switch and index inputs are synchronous to clk_sys
// Notes:   Speed ramps by the accel register once per ramp tick
`timescale 1ns/10ps

module shs_homing_sequencer (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        home_switch,
  input  wire logic        forward_overtravel,
  input  wire logic        reverse_overtravel,
  input  wire logic        encoder_index,
  output logic [15:0]      motor_speed,
  output logic             motor_fwd,
  output logic             homing_busy,
  output logic             homing_done
);
  import shs_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Methods that have a defined trajectory
  function automatic logic method_ok(input logic [7:0] m);
    method_ok = (m >= M_10 && m <= M_14) || (m >= M_17 && m <= M_19);
  endfunction : method_ok

  // Segment word {fwd, fast, event, end kind} per method, path and step
  function automatic logic [5:0] seg_lookup(input logic [7:0] m, input logic [1:0] p,
                                            input logic [1:0] i);
    case ({m, p, i})
      {M_10, P_NORM, 2'h0}:   seg_lookup = {DIR_FWD, SPD_HI, EV_HW_RISE, END_NEXT};
      {M_10, P_NORM, 2'h1}:   seg_lookup = {DIR_FWD, SPD_LO, EV_HW_FALL, END_NEXT};
      {M_10, P_NORM, 2'h2}:   seg_lookup = {DIR_REV, SPD_LO, EV_HW_RISE, END_NEXT};
      {M_10, P_NORM, 2'h3}:   seg_lookup = {DIR_FWD, SPD_LO, EV_HW_FALL, END_IDX};
      {M_10, P_LIMIT, 2'h0}:  seg_lookup = {DIR_REV, SPD_HI, EV_HW_RISE, END_NEXT};
      {M_10, P_LIMIT, 2'h1}:  seg_lookup = {DIR_FWD, SPD_LO, EV_HW_FALL, END_IDX};
      {M_10, P_ACTIVE, 2'h0}: seg_lookup = {DIR_FWD, SPD_LO, EV_HW_FALL, END_IDX};
      {M_11, P_NORM, 2'h0}:   seg_lookup = {DIR_REV, SPD_HI, EV_HW_RISE, END_NEXT};
      {M_11, P_NORM, 2'h1}:   seg_lookup = {DIR_FWD, SPD_LO, EV_HW_FALL, END_IDX};
      {M_11, P_LIMIT, 2'h0}:  seg_lookup = {DIR_FWD, SPD_HI, EV_HW_RISE, END_NEXT};
      {M_11, P_LIMIT, 2'h1}:  seg_lookup = {DIR_FWD, SPD_LO, EV_HW_FALL, END_NEXT};
      {M_11, P_LIMIT, 2'h2}:  seg_lookup = {DIR_REV, SPD_LO, EV_HW_RISE, END_NEXT};
      {M_11, P_LIMIT, 2'h3}:  seg_lookup = {DIR_FWD, SPD_LO, EV_HW_FALL, END_IDX};
      {M_11, P_ACTIVE, 2'h0}: seg_lookup = {DIR_FWD, SPD_LO, EV_HW_FALL, END_IDX};
      {M_12, P_NORM, 2'h0}:   seg_lookup = {DIR_REV, SPD_HI, EV_HW_RISE, END_NEXT};
      {M_12, P_NORM, 2'h1}:   seg_lookup = {DIR_FWD, SPD_LO, EV_HW_FALL, END_NEXT};
      {M_12, P_NORM, 2'h2}:   seg_lookup = {DIR_REV, SPD_LO, EV_HW_RISE, END_IDX};
      {M_12, P_LIMIT, 2'h0}:  seg_lookup = {DIR_FWD, SPD_HI, EV_HW_RISE, END_NEXT};
      {M_12, P_LIMIT, 2'h1}:  seg_lookup = {DIR_FWD, SPD_LO, EV_HW_FALL, END_NEXT};
      {M_12, P_LIMIT, 2'h2}:  seg_lookup = {DIR_REV, SPD_LO, EV_HW_RISE, END_IDX};
      {M_12, P_ACTIVE, 2'h0}: seg_lookup = {DIR_FWD, SPD_LO, EV_HW_FALL, END_NEXT};
      {M_12, P_ACTIVE, 2'h1}: seg_lookup = {DIR_REV, SPD_LO, EV_HW_RISE, END_IDX};
      {M_13, P_NORM, 2'h0}:   seg_lookup = {DIR_REV, SPD_HI, EV_HW_FALL, END_NEXT};
      {M_13, P_NORM, 2'h1}:   seg_lookup = {DIR_FWD, SPD_LO, EV_HW_RISE, END_IDX};
      {M_13, P_LIMIT, 2'h0}:  seg_lookup = {DIR_FWD, SPD_HI, EV_HW_RISE, END_NEXT};
      {M_13, P_LIMIT, 2'h1}:  seg_lookup = {DIR_REV, SPD_LO, EV_HW_FALL, END_NEXT};
      {M_13, P_LIMIT, 2'h2}:  seg_lookup = {DIR_FWD, SPD_LO, EV_HW_RISE, END_IDX};
      {M_13, P_ACTIVE, 2'h0}: seg_lookup = {DIR_REV, SPD_LO, EV_HW_FALL, END_NEXT};
      {M_13, P_ACTIVE, 2'h1}: seg_lookup = {DIR_FWD, SPD_LO, EV_HW_RISE, END_IDX};
      {M_14, P_NORM, 2'h0}:   seg_lookup = {DIR_REV, SPD_HI, EV_HW_RISE, END_NEXT};
      {M_14, P_NORM, 2'h1}:   seg_lookup = {DIR_REV, SPD_LO, EV_HW_FALL, END_NEXT};
      {M_14, P_NORM, 2'h2}:   seg_lookup = {DIR_FWD, SPD_LO, EV_HW_RISE, END_NEXT};
      {M_14, P_NORM, 2'h3}:   seg_lookup = {DIR_REV, SPD_LO, EV_HW_FALL, END_IDX};
      {M_14, P_LIMIT, 2'h0}:  seg_lookup = {DIR_FWD, SPD_HI, EV_HW_RISE, END_NEXT};
      {M_14, P_LIMIT, 2'h1}:  seg_lookup = {DIR_REV, SPD_LO, EV_HW_FALL, END_IDX};
      {M_14, P_ACTIVE, 2'h0}: seg_lookup = {DIR_REV, SPD_LO, EV_HW_FALL, END_IDX};
      {M_17, P_NORM, 2'h0}:   seg_lookup = {DIR_REV, SPD_HI, EV_OT_RISE, END_NEXT};
      {M_17, P_NORM, 2'h1}:   seg_lookup = {DIR_FWD, SPD_LO, EV_OT_FALL, END_EVT};
      {M_17, P_ACTIVE, 2'h0}: seg_lookup = {DIR_FWD, SPD_LO, EV_OT_FALL, END_EVT};
      {M_18, P_NORM, 2'h0}:   seg_lookup = {DIR_FWD, SPD_HI, EV_OT_RISE, END_NEXT};
      {M_18, P_NORM, 2'h1}:   seg_lookup = {DIR_REV, SPD_LO, EV_OT_FALL, END_EVT};
      {M_18, P_ACTIVE, 2'h0}: seg_lookup = {DIR_REV, SPD_LO, EV_OT_FALL, END_EVT};
      {M_19, P_NORM, 2'h0}:   seg_lookup = {DIR_FWD, SPD_HI, EV_HW_RISE, END_NEXT};
      {M_19, P_NORM, 2'h1}:   seg_lookup = {DIR_REV, SPD_LO, EV_HW_FALL, END_EVT};
      {M_19, P_ACTIVE, 2'h0}: seg_lookup = {DIR_REV, SPD_LO, EV_HW_FALL, END_EVT};
      default:                seg_lookup = {DIR_REV, SPD_LO, EV_HW_RISE, END_NONE};
    endcase
  endfunction : seg_lookup

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  shs_state_t  state_reg;
  logic [1:0]  path_reg;
  logic [1:0]  idx_reg;
  logic [7:0]  method_reg;
  logic [15:0] high_reg;
  logic [15:0] low_reg;
  logic [15:0] accel_reg;
  logic [15:0] vel_reg;
  logic [15:0] vel_next;
  logic        dir_reg;
  logic        done_reg;
  logic        err_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [7:0]  tick_cnt_reg;
  logic        tick_reg;
  logic        hw_prev_reg;
  logic        fot_prev_reg;
  logic        rot_prev_reg;
  logic        idx_prev_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Master sees waitrequest low one cycle after it raises a request
  wire         req_any   = avs_read | avs_write;
  wire         wr_fire   = avs_write & ~wait_reg;
  wire [31:0]  wmask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire         cfg_wr    = wr_fire & (state_reg == ST_IDLE);
  wire         start_req = cfg_wr & (avs_address == OFF_CTRL) & avs_byteenable[0]
                           & avs_writedata[CTRL_START_BIT];
  wire [31:0]  status    = {vel_reg, 8'h00, idx_reg, path_reg, dir_reg, err_reg,
                            done_reg, state_reg != ST_IDLE};
  wire [31:0]  rdata_mux = (avs_address == OFF_METHOD)   ? {24'h000000, method_reg} :
                           (avs_address == OFF_HIGH_SPD) ? {16'h0000, high_reg} :
                           (avs_address == OFF_LOW_SPD)  ? {16'h0000, low_reg} :
                           (avs_address == OFF_ACCEL)    ? {16'h0000, accel_reg} :
                           (avs_address == OFF_STATUS)   ? status : 32'h00000000;

  // Byte-lane merge for configuration writes
  wire [31:0] merge_method = ({24'h000000, method_reg} & ~wmask) | (avs_writedata & wmask);
  wire [31:0] merge_high   = ({16'h0000, high_reg} & ~wmask) | (avs_writedata & wmask);
  wire [31:0] merge_low    = ({16'h0000, low_reg} & ~wmask) | (avs_writedata & wmask);
  wire [31:0] merge_accel  = ({16'h0000, accel_reg} & ~wmask) | (avs_writedata & wmask);

  // ----------------------------------------------------------------
  // Edge detection and segment decode
  // ----------------------------------------------------------------
  // Inputs are already synchronous; one stage of history gives edges
  wire        hw_rise   = home_switch & ~hw_prev_reg;
  wire        hw_fall   = ~home_switch & hw_prev_reg;
  wire        ot_lvl    = (method_reg == M_17) ? reverse_overtravel : forward_overtravel;
  wire        ot_prev   = (method_reg == M_17) ? rot_prev_reg : fot_prev_reg;
  wire        ot_rise   = ot_lvl & ~ot_prev;
  wire        ot_fall   = ~ot_lvl & ot_prev;
  wire        idx_rise  = encoder_index & ~idx_prev_reg;
  wire [5:0]  seg       = seg_lookup(method_reg, path_reg, idx_reg);
  wire        seg_fwd   = seg[5];
  wire        seg_fast  = seg[4];
  wire [1:0]  seg_evt   = seg[3:2];
  wire [1:0]  seg_end   = seg[1:0];
  wire        evt_hit   = (seg_evt == EV_HW_RISE) ? hw_rise :
                          (seg_evt == EV_HW_FALL) ? hw_fall :
                          (seg_evt == EV_OT_RISE) ? ot_rise : ot_fall;
  wire        is_switch = (method_reg >= M_10) && (method_reg <= M_14);
  wire        fwd_first = (method_reg == M_10);
  wire        limit_hit = is_switch && (path_reg == P_NORM) && (idx_reg == 2'h0)
                          && (fwd_first ? forward_overtravel : reverse_overtravel);
  wire        start_act = (method_reg == M_17) ? reverse_overtravel :
                          (method_reg == M_18) ? forward_overtravel : home_switch;

  // ----------------------------------------------------------------
  // Velocity ramp
  // ----------------------------------------------------------------
  // Target drops to zero while turning round or stopping
  wire        running = (state_reg == ST_SEG) || (state_reg == ST_ARMED);
  wire [15:0] tgt_spd = (running && (seg_fwd == dir_reg)) ?
                        (seg_fast ? high_reg : low_reg) : 16'h0000;
  wire [15:0] up_gap  = tgt_spd - vel_reg;
  wire [15:0] dn_gap  = vel_reg - tgt_spd;

  // One accel step per tick, never overshooting the target
  always_comb
  begin
    vel_next = vel_reg;
    if (tick_reg && (vel_reg < tgt_spd))
    begin
      vel_next = (up_gap > accel_reg) ? (vel_reg + accel_reg) : tgt_spd;
    end
    else if (tick_reg && (vel_reg > tgt_spd))
    begin
      vel_next = (dn_gap > accel_reg) ? (vel_reg - accel_reg) : tgt_spd;
    end
  end

  // Ramp tick divider
  always_ff @(posedge clk_sys)
  begin
    if (rst || (tick_cnt_reg == 8'(RAMP_TICK_CYC - 1)))
      tick_cnt_reg <= 8'h00;
    else
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
    tick_reg <= ~rst & (tick_cnt_reg == 8'(RAMP_TICK_CYC - 1));
  end

  // Speed and direction; direction turns only at standstill
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      vel_reg <= 16'h0000;
      dir_reg <= DIR_FWD;
    end
    else
    begin
      vel_reg <= vel_next;
      if (running && (vel_reg == 16'h0000) && (seg_fwd != dir_reg))
        dir_reg <= seg_fwd;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Walks the segment table; limit hit on the first fast leg turns paths
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      path_reg  <= P_NORM;
      idx_reg   <= 2'h0;
      done_reg  <= 1'b0;
      err_reg   <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (start_req)
          begin
            done_reg  <= 1'b0;
            err_reg   <= ~method_ok(method_reg);
            idx_reg   <= 2'h0;
            path_reg  <= start_act ? P_ACTIVE : P_NORM;
            state_reg <= method_ok(method_reg) ? ST_SEG : ST_IDLE;
          end
        end
        ST_SEG:
        begin
          if (limit_hit)
          begin
            path_reg <= P_LIMIT;
            idx_reg  <= 2'h0;
          end
          else if (evt_hit && (seg_end == END_NEXT))
            idx_reg <= idx_reg + 2'h1;
          else if (evt_hit && (seg_end == END_IDX))
            state_reg <= ST_ARMED;
          else if (evt_hit && (seg_end == END_EVT))
            state_reg <= ST_STOP;
        end
        ST_ARMED:
        begin
          if (idx_rise)
            state_reg <= ST_STOP;
        end
        ST_STOP:
        begin
          if (vel_reg == 16'h0000)
          begin
            state_reg <= ST_IDLE;
            done_reg  <= 1'b1;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file and bus answer
  // ----------------------------------------------------------------
  // Configuration is frozen while a homing run is active
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      method_reg <= METHOD_RST;
      high_reg   <= HIGH_SPD_RST;
      low_reg    <= LOW_SPD_RST;
      accel_reg  <= ACCEL_RST;
      wait_reg   <= 1'b1;
      rdata_reg  <= 32'h00000000;
    end
    else
    begin
      wait_reg <= ~(req_any & wait_reg);
      if (avs_read && wait_reg)
        rdata_reg <= rdata_mux;
      if (cfg_wr && (avs_address == OFF_METHOD))
        method_reg <= merge_method[7:0];
      if (cfg_wr && (avs_address == OFF_HIGH_SPD))
        high_reg <= merge_high[15:0];
      if (cfg_wr && (avs_address == OFF_LOW_SPD))
        low_reg <= merge_low[15:0];
      if (cfg_wr && (avs_address == OFF_ACCEL))
        accel_reg <= merge_accel[15:0];
    end
  end

  // Input history for edge detection
  always_ff @(posedge clk_sys)
  begin
    hw_prev_reg  <= ~rst & home_switch;
    fot_prev_reg <= ~rst & forward_overtravel;
    rot_prev_reg <= ~rst & reverse_overtravel;
    idx_prev_reg <= ~rst & encoder_index;
  end

  // Outputs straight from flip-flops, except homing_busy decoded from state_reg
  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign motor_speed     = vel_reg;
  assign motor_fwd       = dir_reg;
  assign homing_busy     = running | (state_reg == ST_STOP);
  assign homing_done     = done_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_bad_method;
    @(posedge clk_sys) disable iff (rst)
      (state_reg == ST_IDLE && start_req && !method_ok(method_reg))
      |=> (err_reg && state_reg == ST_IDLE) [*2];
  endproperty
  a_bad_method: assert property (p_bad_method) else $error("undefined method moved");

  property p_limit_turn;
    @(posedge clk_sys) disable iff (rst)
      (state_reg == ST_SEG && limit_hit) |=> (path_reg == P_LIMIT && idx_reg == 2'h0);
  endproperty
  a_limit_turn: assert property (p_limit_turn) else $error("limit did not turn path");

  property p_idx_stop;
    @(posedge clk_sys) disable iff (rst)
      (state_reg == ST_ARMED && idx_rise) |=> (state_reg == ST_STOP);
  endproperty
  a_idx_stop: assert property (p_idx_stop) else $error("index pulse did not stop");

  property p_m19_no_idx;
    @(posedge clk_sys) disable iff (rst)
      (method_reg == M_19) |-> (state_reg != ST_ARMED);
  endproperty
  a_m19_no_idx: assert property (p_m19_no_idx) else $error("method 19 waits on index");

  property p_ramp_tick;
    @(posedge clk_sys) disable iff (rst)
      (!tick_reg) |=> $stable(vel_reg);
  endproperty
  a_ramp_tick: assert property (p_ramp_tick) else $error("speed changed off tick");

  property p_dir_rest;
    @(posedge clk_sys) disable iff (rst)
      (!$stable(dir_reg)) |-> ($past(vel_reg) == 16'h0000);
  endproperty
  a_dir_rest: assert property (p_dir_rest) else $error("direction turned in motion");

  property p_active_start;
    @(posedge clk_sys) disable iff (rst)
      (state_reg == ST_IDLE && start_req && is_switch && home_switch)
      |=> (path_reg == P_ACTIVE && state_reg == ST_SEG);
  endproperty
  a_active_start: assert property (p_active_start) else $error("active start path");

  property p_done;
    @(posedge clk_sys) disable iff (rst)
      (state_reg == ST_STOP && vel_reg == 16'h0000) |=> (done_reg && !homing_busy);
  endproperty
  a_done: assert property (p_done) else $error("done not raised at stop");

  property p_evt_stop;
    @(posedge clk_sys) disable iff (rst)
      (state_reg == ST_SEG && !limit_hit && evt_hit && seg_end == END_EVT)
      |=> (state_reg == ST_STOP) ##1 (homing_busy && !done_reg);
  endproperty
  a_evt_stop: assert property (p_evt_stop) else $error("edge did not stop run");

endmodule : shs_homing_sequencer

/* File: shs_pkg.sv */
// Purpose: Shared constants and types for the homing sequencer
// Assumes: 200 MHz system clock, Avalon-MM byte addressing
// Notes:   Segment words pack direction, speed, end event and end kind
package shs_pkg;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [4:0]  OFF_CTRL       = 5'h00;
  localparam logic [4:0]  OFF_METHOD     = 5'h04;
  localparam logic [4:0]  OFF_HIGH_SPD   = 5'h08;
  localparam logic [4:0]  OFF_LOW_SPD    = 5'h0C;
  localparam logic [4:0]  OFF_ACCEL      = 5'h10;
  localparam logic [4:0]  OFF_STATUS     = 5'h14;
  localparam int          CTRL_START_BIT = 0;
  localparam logic [7:0]  METHOD_RST     = 8'h0A;
  localparam logic [15:0] HIGH_SPD_RST   = 16'h03E8;
  localparam logic [15:0] LOW_SPD_RST    = 16'h0064;
  localparam logic [15:0] ACCEL_RST      = 16'h0010;

  // ----------------------------------------------------------------
  // Homing method codes
  // ----------------------------------------------------------------
  localparam logic [7:0] M_10 = 8'h0A;
  localparam logic [7:0] M_11 = 8'h0B;
  localparam logic [7:0] M_12 = 8'h0C;
  localparam logic [7:0] M_13 = 8'h0D;
  localparam logic [7:0] M_14 = 8'h0E;
  localparam logic [7:0] M_17 = 8'h11;
  localparam logic [7:0] M_18 = 8'h12;
  localparam logic [7:0] M_19 = 8'h13;

  // ----------------------------------------------------------------
  // Paths, segment fields and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] P_NORM     = 2'h0;
  localparam logic [1:0] P_LIMIT    = 2'h1;
  localparam logic [1:0] P_ACTIVE   = 2'h2;
  localparam logic       DIR_FWD    = 1'b1;
  localparam logic       DIR_REV    = 1'b0;
  localparam logic       SPD_HI     = 1'b1;
  localparam logic       SPD_LO     = 1'b0;
  localparam logic [1:0] EV_HW_RISE = 2'h0;
  localparam logic [1:0] EV_HW_FALL = 2'h1;
  localparam logic [1:0] EV_OT_RISE = 2'h2;
  localparam logic [1:0] EV_OT_FALL = 2'h3;
  localparam logic [1:0] END_NEXT   = 2'h0;
  localparam logic [1:0] END_IDX    = 2'h1;
  localparam logic [1:0] END_EVT    = 2'h2;
  localparam logic [1:0] END_NONE   = 2'h3;
  localparam int         CLK_PERIOD_NS  = 5;
  localparam int         RAMP_TICK_NS   = 1000;
  localparam int         RAMP_TICK_CYC  = RAMP_TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_SEG, ST_ARMED, ST_STOP} shs_state_t;

endpackage : shs_pkg

/* File: shs_axis_model.sv */
// Purpose: Axis model giving switch and index levels
// Assumes: One speed unit moves the axis one count per cycle
// Notes:   Index is high for 64 counts in every 16384
`timescale 1ns/10ps
module shs_axis_model (
  input  wire logic        clk_sys,
  input  wire logic        load,
  input  wire logic [31:0] load_pos,
  input  wire logic [15:0] motor_speed,
  input  wire logic        motor_fwd,
  output logic             home_switch,
  output logic             forward_overtravel,
  output logic             reverse_overtravel,
  output logic             encoder_index,
  output logic [31:0]      pos
);
  // Position follows commanded speed and direction
  always_ff @(posedge clk_sys)
  begin
    if (load)
      pos <= load_pos;
    else if (motor_fwd)
      pos <= pos + 32'(motor_speed);
    else
      pos <= pos - 32'(motor_speed);
  end
  // Switches are fixed windows along the travel
  assign home_switch        = pos > 32'h00132000 && pos < 32'h00152000;
  assign forward_overtravel = pos >= 32'h00200000;
  assign reverse_overtravel = pos < 32'h00080000;
  assign encoder_index      = pos[13:6] == 8'h00;
endmodule : shs_axis_model

/* File: shs_homing_sequencer_tb.sv */
// Purpose: Self-checking bench for the homing sequencer
// Assumes: Axis model closes the loop on speed and direction
// Notes:   Speeds are cut down so each run stays short
`timescale 1ns/10ps
module shs_homing_sequencer_tb;
  import shs_pkg::*;
  logic        clk_sys, rst, avs_read, avs_write, load, motor_fwd;
  logic        home_switch, forward_overtravel, reverse_overtravel;
  logic        encoder_index, avs_waitrequest, homing_busy, homing_done;
  logic [4:0]  avs_address;
  logic [15:0] motor_speed;
  logic [31:0] avs_writedata, avs_readdata, q, pos, load_pos;
  int          fails, checks, cyc;
  shs_homing_sequencer i_dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .home_switch,
    .forward_overtravel, .reverse_overtravel, .encoder_index, .motor_speed, .motor_fwd,
    .homing_busy, .homing_done);
  shs_axis_model i_axis (.clk_sys, .load, .load_pos, .motor_speed, .motor_fwd, .home_switch,
    .forward_overtravel, .reverse_overtravel, .encoder_index, .pos);
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic home(input logic [7:0] m, input logic [31:0] p0, lo, hi, input logic dir);
    load_pos <= p0;
    load     <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
    bus(1'b1, OFF_METHOD, 32'(m));
    bus(1'b1, OFF_CTRL, 32'h00000001);
    repeat (2) @(posedge clk_sys);
    chk("busy", 32'h1, 32'(homing_busy));
    while (homing_done !== 1'b1)
      @(posedge clk_sys);
    @(posedge clk_sys);
    chk("idle", 32'h0, {homing_busy, motor_speed});
    chk("dir", 32'(dir), 32'(motor_fwd));
    chk("stop_pos", 32'h1, 32'(pos > lo && pos < hi));
  endtask : home
  task automatic t_regs;
    bus(1'b0, OFF_HIGH_SPD, 32'h0);
    chk("high_rst", 32'(HIGH_SPD_RST), q);
    bus(1'b0, 5'h18, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, OFF_HIGH_SPD, 32'h00000040);
    bus(1'b1, OFF_LOW_SPD, 32'h00000010);
    bus(1'b0, OFF_LOW_SPD, 32'h0);
    chk("low_wr", 32'h00000010, q);
  endtask : t_regs
  task automatic t_undef;
    for (int m = 15; m <= 16; m++)
    begin
      bus(1'b1, OFF_METHOD, 32'(m));
      bus(1'b1, OFF_CTRL, 32'h00000001);
      repeat (20) @(posedge clk_sys);
      chk("no_move", 32'h0, {homing_busy, motor_speed});
      bus(1'b0, OFF_STATUS, 32'h0);
      chk("err", 32'h4, q & 32'h00000005);
    end
  endtask : t_undef
  task automatic t_m10;
    home(M_10, 32'h00100000, 32'h00154000, 32'h00156000, 1'b1);
  endtask : t_m10
  task automatic t_m10l;
    home(M_10, 32'h00160000, 32'h00154000, 32'h00156000, 1'b1);
  endtask : t_m10l
  task automatic t_m11a;
    home(M_11, 32'h00140000, 32'h00154000, 32'h00156000, 1'b1);
  endtask : t_m11a
  task automatic t_m19a;
    home(M_19, 32'h00140000, 32'h00130000, 32'h00132001, 1'b0);
  endtask : t_m19a
  task automatic t_m17;
    home(M_17, 32'h00100000, 32'h0007FFFF, 32'h00081000, 1'b1);
  endtask : t_m17
  task automatic t_m18a;
    home(M_18, 32'h00201000, 32'h001FF000, 32'h00200000, 1'b0);
  endtask : t_m18a
  // Clock at 200 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = !clk_sys;
  end
  // Run ceiling against hangs
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fails++;
      end_of_test();
    end
  end
  // Main sequence
  initial
  begin
    {rst, avs_read, avs_write, load, avs_address, avs_writedata, load_pos} = '1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    load_pos = 32'h00100000;
    {fails, checks} = '0;
    repeat (20) @(posedge clk_sys);
    rst  <= 1'b0;
    load <= 1'b0;
    t_regs();
    t_undef();
    t_m10();
    t_m10l();
    t_m11a();
    t_m19a();
    t_m17();
    t_m18a();
    end_of_test();
  end
endmodule : shs_homing_sequencer_tb
